// *** shared/rlcb_pkg.sv ***
// Package for the radio link register bank: offsets, field positions, carriers.
// Assumes a single 20 MHz system clock and word-wide register accesses.
package rlcb_pkg;

	localparam int unsigned DATA_W    = 32;
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned WORD_SH   = 2;
	localparam int unsigned INDEX_W   = ADDR_W - WORD_SH;

	// Byte offsets of the bank
	localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CTRL_STATUS  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LAYER1_STATUS          = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LAYER1_CONFIG          = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LINE_RATE_CONFIG       = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_PROTOCOL_VERSION_CTRL  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_TX_SCRAMBLER_CTRL      = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RX_SCRAMBLER_STATUS    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_MGMT_PLANE_CONFIG      = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_MGMT_PLANE_STATUS      = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STARTUP_SEQUENCE_CTRL  = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_STARTUP_TIMER_CTRL     = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_INBAND_ALARM_CTRL      = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_CONTROL_WORD_POINTER   = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_TX_CONTROL_WORD        = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RX_CONTROL_WORD        = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_RX_ERROR_STATUS        = 8'h3c;
	localparam logic [ADDR_W-1:0] OFS_RX_RADIO_FRAME_COUNT   = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_LOOPBACK_CTRL          = 8'h44;
	localparam logic [ADDR_W-1:0] OFS_TX_BUFFER_LATENCY      = 8'h48;
	localparam logic [ADDR_W-1:0] OFS_RX_BUFFER_LATENCY      = 8'h4c;
	localparam logic [ADDR_W-1:0] OFS_TX_EXTENDED_LATENCY    = 8'h50;
	localparam logic [ADDR_W-1:0] OFS_RX_EXTENDED_LATENCY    = 8'h54;
	localparam logic [ADDR_W-1:0] OFS_LOOP_LATENCY           = 8'h58;
	localparam logic [ADDR_W-1:0] OFS_SERDES_SLIP_CTRL       = 8'h5c;
	localparam logic [ADDR_W-1:0] OFS_ONEWAY_CAL_CTRL_A      = 8'h60;
	localparam logic [ADDR_W-1:0] OFS_ONEWAY_CAL_CTRL_E      = 8'h70;
	localparam logic [ADDR_W-1:0] OFS_ONEWAY_CAL_STATUS      = 8'h74;
	localparam logic [ADDR_W-1:0] OFS_RESERVED_HOLE_A        = 8'h78;
	localparam logic [ADDR_W-1:0] OFS_RESERVED_HOLE_B        = 8'h7c;
	localparam logic [ADDR_W-1:0] OFS_LOOP_CAL_CTRL_STATUS   = 8'h80;
	localparam logic [ADDR_W-1:0] OFS_SERDES_TX_FIFO_LATENCY = 8'h84;
	localparam logic [ADDR_W-1:0] OFS_SERDES_RX_FIFO_LATENCY = 8'h88;
	localparam logic [ADDR_W-1:0] OFS_CORE_INFORMATION       = 8'h8c;
	localparam logic [ADDR_W-1:0] OFS_DIAGNOSTIC_STATUS      = 8'ha0;

	// Interrupt register field positions
	localparam int unsigned BIT_SDI_PENDING   = 18;
	localparam int unsigned BIT_RAI_PENDING   = 17;
	localparam int unsigned BIT_RESET_PENDING = 16;
	localparam int unsigned BIT_SDI_EN        = 2;
	localparam int unsigned BIT_RAI_EN        = 1;
	localparam int unsigned BIT_RESET_EN      = 0;

	localparam logic [DATA_W-1:0] INTR_RESET_VALUE = 32'h0000_0000;
	// Reserved reads are undefined; this bank returns zero
	localparam logic [DATA_W-1:0] RESERVED_ACCESS_CODE = 32'h0000_0000;

	// One event per interrupt source
	typedef struct packed {
		logic sdi;
		logic rai;
		logic rst;
	} rlcb_event_t;

	// Register bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} rlcb_req_t;

endpackage : rlcb_pkg

// *** logic/rlcb_bank.sv ***
// Register bank of the radio link core; full decode of the interrupt register.
// Assumes the host issues whole-word accesses and remote events are synchronous.
`timescale 1ns/10ps
`default_nettype none

module rlcb_bank
(
	input  wire logic                        clk_sys_in,
	input  wire logic                        sys_rst_in,
	input  wire logic                        bus_write_in,
	input  wire logic                        bus_read_in,
	input  wire logic [rlcb_pkg::ADDR_W-1:0] bus_address_in,
	input  wire logic [rlcb_pkg::DATA_W-1:0] bus_writedata_in,
	output var  logic [rlcb_pkg::DATA_W-1:0] bus_readdata_out,
	output var  logic                        bus_readdatavalid_out,
	output var  logic                        bus_waitrequest_out,
	input  wire logic                        remote_sdi_event_in,
	input  wire logic                        remote_rai_event_in,
	input  wire logic                        remote_reset_event_in,
	output var  logic                        irq_out,
	output var  logic [2:0]                  intr_enable_out
);
	import rlcb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	rlcb_req_t   req;
	rlcb_event_t evt;
	logic        hit_intr;
	logic        intr_wr;
	logic        sdi_pending;
	logic        rai_pending;
	logic        rst_pending;
	logic        sdi_en;
	logic        rai_en;
	logic        rst_en;
	logic [DATA_W-1:0] intr_word;
	logic [DATA_W-1:0] next_readdata;

	// True when an address selects the given register word
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		addr_is = (a[ADDR_W-1:WORD_SH] == ofs[ADDR_W-1:WORD_SH]);
	endfunction : addr_is

	// True for the hole words and for space past the core information word, except the diagnostic status word
	function automatic logic addr_reserved(input logic [ADDR_W-1:0] a);
		addr_reserved = addr_is(a, OFS_RESERVED_HOLE_A) || addr_is(a, OFS_RESERVED_HOLE_B)
			|| (a > OFS_CORE_INFORMATION && !addr_is(a, OFS_DIAGNOSTIC_STATUS));
	endfunction : addr_reserved

	assign req.wr    = bus_write_in;
	assign req.rd    = bus_read_in;
	assign req.addr  = bus_address_in;
	assign req.wdata = bus_writedata_in;
	assign evt.sdi   = remote_sdi_event_in;
	assign evt.rai   = remote_rai_event_in;
	assign evt.rst   = remote_reset_event_in;

	// Whole-word only; low address bits are ignored, no lanes exist
	assign hit_intr = addr_is(req.addr, OFS_INTERRUPT_CTRL_STATUS);
	assign intr_wr  = req.wr && hit_intr;

	// Bank never stalls, so every access is accepted the same cycle; read data follows one cycle later
	assign bus_waitrequest_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt enables

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			sdi_en <= INTR_RESET_VALUE[BIT_SDI_EN];
			rai_en <= INTR_RESET_VALUE[BIT_RAI_EN];
			rst_en <= INTR_RESET_VALUE[BIT_RESET_EN];
		end
		else if (intr_wr)
		begin
			sdi_en <= req.wdata[BIT_SDI_EN];
			rai_en <= req.wdata[BIT_RAI_EN];
			rst_en <= req.wdata[BIT_RESET_EN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pending flags; a same-cycle event on an enabled source beats a software write of zero

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			sdi_pending <= INTR_RESET_VALUE[BIT_SDI_PENDING];
			rai_pending <= INTR_RESET_VALUE[BIT_RAI_PENDING];
			rst_pending <= INTR_RESET_VALUE[BIT_RESET_PENDING];
		end
		else
		begin
			if (evt.sdi && sdi_en)
				sdi_pending <= 1'b1;
			else if (intr_wr)
				sdi_pending <= req.wdata[BIT_SDI_PENDING];
			if (evt.rai && rai_en)
				rai_pending <= 1'b1;
			else if (intr_wr)
				rai_pending <= req.wdata[BIT_RAI_PENDING];
			if (evt.rst && rst_en)
				rst_pending <= 1'b1;
			else if (intr_wr)
				rst_pending <= req.wdata[BIT_RESET_PENDING];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	always_comb
	begin
		intr_word = '0;
		intr_word[BIT_SDI_PENDING]   = sdi_pending;
		intr_word[BIT_RAI_PENDING]   = rai_pending;
		intr_word[BIT_RESET_PENDING] = rst_pending;
		intr_word[BIT_SDI_EN]        = sdi_en;
		intr_word[BIT_RAI_EN]        = rai_en;
		intr_word[BIT_RESET_EN]      = rst_en;
	end

	// Registers outside this bank's scope read as the reserved code too
	always_comb
	begin
		next_readdata = RESERVED_ACCESS_CODE;
		if (hit_intr && !addr_reserved(req.addr))
			next_readdata = intr_word;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			bus_readdata_out      <= '0;
			bus_readdatavalid_out <= 1'b0;
		end
		else
		begin
			bus_readdatavalid_out <= req.rd;
			if (req.rd)
				bus_readdata_out <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			irq_out <= 1'b0;
		else
			irq_out <= sdi_pending | rai_pending | rst_pending;
	end

	assign intr_enable_out = {sdi_en, rai_en, rst_en};

endmodule : rlcb_bank

`default_nettype wire

// *** verification/rlcb_monitor.sv ***
// Port checker for the register bank, bound into every rlcb_bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module rlcb_monitor
(
	input wire logic                        clk_sys_in,
	input wire logic                        sys_rst_in,
	input wire logic                        bus_write_in,
	input wire logic                        bus_read_in,
	input wire logic [rlcb_pkg::ADDR_W-1:0] bus_address_in,
	input wire logic [rlcb_pkg::DATA_W-1:0] bus_writedata_in,
	input wire logic [rlcb_pkg::DATA_W-1:0] bus_readdata_out,
	input wire logic                        bus_readdatavalid_out,
	input wire logic                        bus_waitrequest_out,
	input wire logic                        remote_sdi_event_in,
	input wire logic                        irq_out,
	input wire logic [2:0]                  intr_enable_out
);
	import rlcb_pkg::*;
	wire logic at0 = (bus_address_in[7:2] == 6'h00);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////
	property p_rd_lat; bus_read_in |=> bus_readdatavalid_out; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
	property p_rd_once; !bus_read_in |=> !bus_readdatavalid_out; endproperty
	a_rd_once: assert property (p_rd_once) else $error("stray read valid");
	property p_no_wait; !bus_waitrequest_out; endproperty
	a_no_wait: assert property (p_no_wait) else $error("bus stalled");
	property p_en_wr; bus_write_in && at0 |=> intr_enable_out == $past(bus_writedata_in[2:0]);
	endproperty
	a_en_wr: assert property (p_en_wr) else $error("enable write lost");
	property p_en_keep; !(bus_write_in && at0) |=> $stable(intr_enable_out); endproperty
	a_en_keep: assert property (p_en_keep) else $error("enable moved");
	property p_evt_irq; remote_sdi_event_in && intr_enable_out[2] |-> ##2 irq_out; endproperty
	a_evt_irq: assert property (p_evt_irq) else $error("no request after event");
	property p_rd_ctl; bus_read_in && at0 && !bus_write_in |=>
		bus_readdata_out[2:0] == $past(intr_enable_out) && (bus_readdata_out & 32'hfff8_fff8) == 0;
	endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("bad readback");
	property p_rd_irq; bus_read_in && at0 |=> irq_out == (|bus_readdata_out[18:16]); endproperty
	a_rd_irq: assert property (p_rd_irq) else $error("request not flag OR");
	property p_rd_rsvd; bus_read_in && !at0 |=> bus_readdata_out == RESERVED_ACCESS_CODE;
	endproperty
	a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read value");
	c_irq: cover property ($rose(irq_out));
	c_rd: cover property (bus_readdatavalid_out && bus_readdata_out[18]);
	c_wr: cover property (bus_write_in && !at0);
endmodule : rlcb_monitor
bind rlcb_bank rlcb_monitor i_mon (.clk_sys_in, .sys_rst_in, .bus_write_in, .bus_read_in,
	.bus_address_in, .bus_writedata_in, .bus_readdata_out, .bus_readdatavalid_out,
	.bus_waitrequest_out, .remote_sdi_event_in, .irq_out, .intr_enable_out);
`default_nettype wire

// *** verification/rlcb_host.sv ***
// Host processor model: whole-word reads and writes on the bank bus.
// Assumes the bank never stalls and answers a read one cycle later.
`timescale 1ns/10ps
`default_nettype none
module rlcb_host
(
	input  wire logic                        clk_sys_in,
	input  wire logic [rlcb_pkg::DATA_W-1:0] bus_readdata_in,
	input  wire logic                        bus_readdatavalid_in,
	output var  logic                        bus_write_out = 1'b0,
	output var  logic                        bus_read_out = 1'b0,
	output var  logic [rlcb_pkg::ADDR_W-1:0] bus_address_out = 8'h00,
	output var  logic [rlcb_pkg::DATA_W-1:0] bus_writedata_out = 32'h0
);
	import rlcb_pkg::*;
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys_in) #1;
		bus_address_out = a;
		bus_writedata_out = d;
		bus_write_out = 1'b1;
		@(posedge clk_sys_in) #1;
		bus_write_out = 1'b0;
		// Released data must not look still valid
		bus_writedata_out = ~d;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_sys_in) #1;
		bus_address_out = a;
		bus_read_out = 1'b1;
		@(posedge clk_sys_in) #1;
		bus_read_out = 1'b0;
		d = bus_readdatavalid_in ? bus_readdata_in : 'x;
	endtask : rd
endmodule : rlcb_host
`default_nettype wire

// *** verification/rlcb_bank_tb.sv ***
// Self-checking bench for the register bank with a host model.
// Assumes the checker is bound into the bank by its own file.
`timescale 1ns/10ps
`default_nettype none
module rlcb_bank_tb;
	import rlcb_pkg::*;
	logic              clk_sys_in = 1'b0;
	logic              sys_rst_in = 1'b1;
	logic              bus_write_in, bus_read_in, bus_readdatavalid_out, irq_out;
	logic [ADDR_W-1:0] bus_address_in;
	logic [DATA_W-1:0] bus_writedata_in, bus_readdata_out;
	logic [2:0]        intr_enable_out;
	rlcb_event_t       evt = '0;
	int                checked = 0, n_mismatch = 0, cycles = 0;
	rlcb_bank i_dut (.clk_sys_in, .sys_rst_in, .bus_write_in, .bus_read_in, .bus_address_in,
		.bus_writedata_in, .bus_readdata_out, .bus_readdatavalid_out, .bus_waitrequest_out(),
		.remote_sdi_event_in(evt.sdi), .remote_rai_event_in(evt.rai),
		.remote_reset_event_in(evt.rst), .irq_out, .intr_enable_out);
	rlcb_host i_host (.clk_sys_in, .bus_readdata_in(bus_readdata_out),
		.bus_readdatavalid_in(bus_readdatavalid_out), .bus_write_out(bus_write_in),
		.bus_read_out(bus_read_in), .bus_address_out(bus_address_in),
		.bus_writedata_out(bus_writedata_in));
	always #25 clk_sys_in = ~clk_sys_in;
	////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			n_mismatch++;
		end
	endtask : check
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] d;
		i_host.rd(a, d);
		check("readback", d, exp);
	endtask : rdc
	task automatic pulse(input int i);
		@(posedge clk_sys_in) #1;
		evt = rlcb_event_t'(3'b001 << i);
		@(posedge clk_sys_in) #1;
		evt = '0;
	endtask : pulse
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("enables", 32'(intr_enable_out), 32'h0);
		rdc(OFS_INTERRUPT_CTRL_STATUS, INTR_RESET_VALUE);
		$display("reset test done");
	endtask : t_reset
	task automatic t_fields;
		i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'hffff_ffff);
		rdc(OFS_INTERRUPT_CTRL_STATUS, 32'h0007_0007);
		check("irq", 32'(irq_out), 32'h1);
		i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'h0);
		rdc(OFS_INTERRUPT_CTRL_STATUS, 32'h0);
		check("irq", 32'(irq_out), 32'h0);
		$display("field test done");
	endtask : t_fields
	task automatic t_events;
		for (int i = 0; i < 3; i++)
		begin
			i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'h0);
			pulse(i);
			rdc(OFS_INTERRUPT_CTRL_STATUS, 32'h0);
			i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'h1 << i);
			pulse(i);
			rdc(OFS_INTERRUPT_CTRL_STATUS, (32'h1 << i) | (32'h1_0000 << i));
			check("irq", 32'(irq_out), 32'h1);
		end
		$display("event test done");
	endtask : t_events
	// Event and a write of zero to its pending flag land on the same edge; the event must win
	task automatic t_race;
		i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'h0000_0004);
		fork
			i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'h0000_0004);
			pulse(2);
		join
		rdc(OFS_INTERRUPT_CTRL_STATUS, 32'h0004_0004);
		check("irq", 32'(irq_out), 32'h1);
		$display("race test done");
	endtask : t_race
	task automatic t_unmapped;
		logic [ADDR_W-1:0] ofs [4] = '{OFS_LAYER1_STATUS, OFS_RESERVED_HOLE_B, 8'hfc,
			OFS_DIAGNOSTIC_STATUS};
		i_host.wr(OFS_INTERRUPT_CTRL_STATUS, 32'h0000_0005);
		foreach (ofs[k])
			i_host.wr(ofs[k], 32'hffff_ffff);
		rdc(OFS_INTERRUPT_CTRL_STATUS, 32'h0000_0005);
		rdc(OFS_RESERVED_HOLE_A, RESERVED_ACCESS_CODE);
		$display("unmapped test done");
	endtask : t_unmapped
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk_sys_in);
		#1;
		sys_rst_in = 1'b0;
		t_reset();
		t_fields();
		t_events();
		t_race();
		t_unmapped();
		test_done();
	end
endmodule : rlcb_bank_tb
`default_nettype wire
